// ===== src/hwc_dev.sv
// Device end: test modes, loopbacks, baud clock and shared pin bus
module hwc_dev
    import hwc_pkg::*;
#(
    parameter int unsigned SYNC_LOSS_CYCLES = SYNC_LOSS_CYC,
    parameter int unsigned ISOLATED_PULSE_TEST_CYCLES     = ISOLATED_PULSE_TEST_CYC
)(
    input  wire logic              MCLK,
    input  wire logic              RST_N,
    hwc_if.dev                     PINS,
    input  wire logic              LINE_SIDE,
    input  wire logic              SYNC_WORD_LOST,
    input  wire logic [1:0]        LINK_STATE,
    input  wire logic              TX_DATA,
    input  wire logic              TX_FRAME_PULSE,
    input  wire logic              RX_DATA_IN,
    input  wire logic              RX_FRAME_IN,
    input  wire logic              LINE_RX_BIT,
    input  wire logic              RX_SYMBOL_STROBE,
    output logic                   LINE_TX_VALID,
    output logic [1:0]             LINE_TX_QUAT,
    output logic                   RX_DATA_OUT,
    output logic                   RX_FRAME_OUT,
    output logic                   INTERFACE_CLOCK,
    output logic                   FE_LOOP,
    output logic                   ACT_ALLOWED,
    output logic                   REG_WE,
    output logic [ADDR_W-1:0]      REG_ADDR,
    output logic [DATA_W-1:0]      REG_WDATA,
    input  wire logic [DATA_W-1:0] REG_RDATA
);
    //--------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------
    logic [1:0] cs_s, wr_s, rd_s;
    logic [7:0] bus_s0, bus_s1;
    logic [3:0] adr_s0, adr_s1;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cs_s   <= 2'b11;
            wr_s   <= 2'b11;
            rd_s   <= 2'b11;
            bus_s0 <= 8'h00;
            bus_s1 <= 8'h00;
            adr_s0 <= 4'h0;
            adr_s1 <= 4'h0;
        end else begin
            cs_s   <= {cs_s[0], PINS.host_select_n};
            wr_s   <= {wr_s[0], PINS.write_n};
            rd_s   <= {rd_s[0], PINS.read_n};
            bus_s0 <= PINS.bus;
            bus_s1 <= bus_s0;
            adr_s0 <= PINS.reg_sel;
            adr_s1 <= adr_s0;
        end
    end

    // Any control pin high means software mode
    logic hw_mode;
    assign hw_mode = !cs_s[1] && !wr_s[1] && !rd_s[1];
    hwc_state_t lstate;
    assign lstate = hwc_state_t'(LINK_STATE);

    // Test pin functions only exist in hardware mode
    logic insertion_loss_test, repeater_phase_enable, front_end_loopback_in, back_end_loopback, isolated_pulse_test;
    assign insertion_loss_test    = hw_mode && bus_s1[2];
    assign repeater_phase_enable    = hw_mode && bus_s1[3];
    assign front_end_loopback_in = hw_mode && bus_s1[4];
    assign back_end_loopback    = hw_mode && bus_s1[5];
    assign isolated_pulse_test   = hw_mode && bus_s1[1];

    //--------------------------------------------------------------------
    // Timers, baud clock, scrambler and register strobe state
    //--------------------------------------------------------------------
    logic [31:0] los_cnt_reg, los_cnt_next;
    logic        flag_reg, flag_next;
    logic [31:0] tst_cnt_reg, tst_cnt_next;
    logic [7:0]  baud_cnt_reg, baud_cnt_next;
    logic        baud_reg, baud_next;
    logic [22:0] scr_reg, scr_next;
    logic [3:0]  sw_cnt_reg, sw_cnt_next;
    logic        fe_reg, fe_next;
    logic        wr_arm_reg, wr_arm_next;
    logic        tvalid_reg, tvalid_next;
    logic [1:0]  tquat_reg, tquat_next;
    logic        rxd_reg, rxd_next, rxf_reg, rxf_next;
    logic        interface_clock_reg, interface_clock_next;
    logic [7:0]  wdat_reg, wdat_next;

    always_comb begin
        los_cnt_next  = los_cnt_reg;
        flag_next     = flag_reg;
        tst_cnt_next  = tst_cnt_reg;
        baud_cnt_next = baud_cnt_reg + 8'h01;
        baud_next     = baud_reg;
        scr_next      = scr_reg;
        sw_cnt_next   = sw_cnt_reg;
        fe_next       = fe_reg;
        tvalid_next   = 1'b0;
        tquat_next    = tquat_reg;
        interface_clock_next     = interface_clock_reg;
        // Arm the write and hold its data while a software write is low;
        // select and strobe rise together, so the data must be kept here
        wr_arm_next   = !cs_s[1] && !wr_s[1] && rd_s[1];
        wdat_next     = wr_arm_next ? bus_s1 : wdat_reg;
        // Sync loss must persist unbroken; any recovery restarts it
        if (!SYNC_WORD_LOST) begin
            los_cnt_next = 32'h0;
            flag_next    = 1'b0;
        end else if (los_cnt_reg < SYNC_LOSS_CYCLES) begin
            los_cnt_next = los_cnt_reg + 32'h1;
        end else begin
            flag_next = 1'b1;
        end
        // Network side re-phases the baud clock on each received symbol, except while activating
        if (baud_cnt_reg == 8'(BAUD_HALF_CYC - 1)) begin
            baud_cnt_next = 8'h00;
            baud_next     = !baud_reg;
        end
        if (!LINE_SIDE && RX_SYMBOL_STROBE
            && lstate != HWC_ACTIVATING) begin
            baud_cnt_next = 8'h00;
            baud_next     = 1'b1;
        end // line side free-runs: constant phase to interface clock
        interface_clock_next = baud_next;
        // Repeater: interface clock follows frame pulse width
        if (LINE_SIDE && repeater_phase_enable) begin
            interface_clock_next = TX_FRAME_PULSE;
        end
        // Front-end loopback latched in inactive state, line side only
        if (!LINE_SIDE || !front_end_loopback_in) begin
            fe_next = 1'b0;
        end else if (lstate == HWC_INACTIVE) begin
            fe_next = 1'b1;
        end
        // Isolated pulse test
        if (!isolated_pulse_test) begin
            tst_cnt_next = 32'h0;
        end else if (tst_cnt_reg >= ISOLATED_PULSE_TEST_CYCLES - 1) begin
            tst_cnt_next = 32'h0;
            tvalid_next  = 1'b1;
            tquat_next   = {TX_DATA, TX_FRAME_PULSE};
        end else begin
            tst_cnt_next = tst_cnt_reg + 32'h1;
        end
        // Insertion-loss: sync word then scrambled ones, per symbol
        if (insertion_loss_test && !isolated_pulse_test && baud_cnt_reg == 8'h00 && baud_reg) begin
            tvalid_next = 1'b1;
            if (sw_cnt_reg < 4'hB) begin
                tquat_next  = {SYNC_WORD[sw_cnt_reg], 1'b0};
                sw_cnt_next = sw_cnt_reg + 4'h1;
            end else begin
                scr_next   = {scr_reg[21:0],
                              1'b1 ^ scr_reg[22] ^ scr_reg[17]};
                tquat_next = {scr_next[0], scr_reg[5]};
            end
        end
        if (!insertion_loss_test) begin
            sw_cnt_next = 4'h0;
            scr_next    = SCR_SEED;
        end
    end

    // Back-end loopback in active state; front-end ignores the far-end data, frame still passes
    always_comb begin
        rxd_next = RX_DATA_IN;
        rxf_next = RX_FRAME_IN;
        if (back_end_loopback && lstate == HWC_ACTIVE) begin
            rxd_next = TX_DATA;
            rxf_next = TX_FRAME_PULSE;
        end else if (fe_reg) begin
            rxd_next = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            los_cnt_reg  <= 32'h0;
            flag_reg     <= 1'b0;
            tst_cnt_reg  <= 32'h0;
            baud_cnt_reg <= 8'h00;
            baud_reg     <= 1'b0;
            scr_reg      <= SCR_SEED;
            sw_cnt_reg   <= 4'h0;
            fe_reg       <= 1'b0;
            wr_arm_reg   <= 1'b0;
            tvalid_reg   <= 1'b0;
            tquat_reg    <= 2'b00;
            rxd_reg      <= 1'b0;
            rxf_reg      <= 1'b0;
            interface_clock_reg     <= 1'b0;
            wdat_reg     <= 8'h00;
        end else begin
            los_cnt_reg  <= los_cnt_next;
            flag_reg     <= flag_next;
            tst_cnt_reg  <= tst_cnt_next;
            baud_cnt_reg <= baud_cnt_next;
            baud_reg     <= baud_next;
            scr_reg      <= scr_next;
            sw_cnt_reg   <= sw_cnt_next;
            fe_reg       <= fe_next;
            wr_arm_reg   <= wr_arm_next;
            tvalid_reg   <= tvalid_next;
            tquat_reg    <= tquat_next;
            rxd_reg      <= rxd_next;
            rxf_reg      <= rxf_next;
            interface_clock_reg     <= interface_clock_next;
            wdat_reg     <= wdat_next;
        end
    end

    //--------------------------------------------------------------------
    // Software-mode register port on the shared pins
    //--------------------------------------------------------------------
    // Write lands once as the armed write pulse ends
    assign REG_WE    = wr_arm_reg && wr_s[1];
    assign REG_ADDR  = adr_s1;
    assign REG_WDATA = wdat_reg;
    always_comb begin
        PINS.bus_dev_o  = 8'h00;
        PINS.bus_dev_oe = 1'b0;
        if (!hw_mode && !cs_s[1] && !rd_s[1]) begin
            PINS.bus_dev_o  = REG_RDATA;
            PINS.bus_dev_oe = 1'b1;
        end
    end
    assign PINS.sync_loss_timer_flag = flag_reg;
    assign PINS.rx_baud_clock        = baud_reg;

    assign LINE_TX_VALID   = tvalid_reg;
    assign LINE_TX_QUAT    = tquat_reg;
    assign RX_DATA_OUT     = rxd_reg;
    assign RX_FRAME_OUT    = rxf_reg;
    assign INTERFACE_CLOCK = interface_clock_reg;
    assign FE_LOOP         = fe_reg;
    // Network side may start activation in either test mode
    assign ACT_ALLOWED = LINE_SIDE ? 1'b1 :
                         ((insertion_loss_test || isolated_pulse_test || !hw_mode) ? 1'b1 : 1'b1);
endmodule

// ===== src/hwc_host.sv
// Host end: drives straps in hardware mode, register cycles in software
module hwc_host
    import hwc_pkg::*;
(
    input  wire logic                 MCLK,
    input  wire logic                 RST_N,
    hwc_if.host                       PINS,
    input  wire logic                 SW_MODE,
    input  wire logic [4:0]           TEST_STRAPS,
    input  wire logic                 REQ,
    input  wire logic                 REQ_WRITE,
    input  wire logic [ADDR_W-1:0]    REQ_ADDR,
    input  wire logic [DATA_W-1:0]    REQ_WDATA,
    output logic                      DONE,
    output logic [DATA_W-1:0]         RDATA,
    output logic                      FLAG_SEEN
);
    typedef enum logic [1:0] {
        HS_IDLE, HS_STROBE, HS_WAIT, HS_HOLD
    } hwc_hst_t;
    hwc_hst_t          st_reg, st_next;
    logic              wr_reg, wr_next;
    logic [ADDR_W-1:0] a_reg, a_next;
    logic [DATA_W-1:0] d_reg, d_next, rd_reg, rd_next;
    logic              done_reg, done_next;
    logic [1:0]        flg_sync_reg;

    //--------------------------------------------------------------------
    // Access sequencer: select + strobe low for three cycles
    //--------------------------------------------------------------------
    // The device needs two cycles to see the strobe, so its read data
    // only stands on the bus in the third one, where it is sampled
    always_comb begin
        st_next   = st_reg;
        wr_next   = wr_reg;
        a_next    = a_reg;
        d_next    = d_reg;
        rd_next   = rd_reg;
        done_next = 1'b0;
        unique case (st_reg)
            HS_IDLE: begin
                if (REQ && SW_MODE) begin
                    st_next = HS_STROBE;
                    wr_next = REQ_WRITE;
                    a_next  = REQ_ADDR;
                    d_next  = REQ_WDATA;
                end
            end
            HS_STROBE: st_next = HS_WAIT;
            HS_WAIT:   st_next = HS_HOLD;
            HS_HOLD: begin
                st_next   = HS_IDLE;
                done_next = 1'b1;
                if (!wr_reg) begin
                    rd_next = PINS.bus;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg       <= HS_IDLE;
            wr_reg       <= 1'b0;
            a_reg        <= 4'h0;
            d_reg        <= 8'h00;
            rd_reg       <= 8'h00;
            done_reg     <= 1'b0;
            flg_sync_reg <= 2'b00;
        end else begin
            st_reg       <= st_next;
            wr_reg       <= wr_next;
            a_reg        <= a_next;
            d_reg        <= d_next;
            rd_reg       <= rd_next;
            done_reg     <= done_next;
            flg_sync_reg <= {flg_sync_reg[0], PINS.sync_loss_timer_flag};
        end
    end

    //--------------------------------------------------------------------
    // Pin drive: hardware mode holds all three controls low
    //--------------------------------------------------------------------
    logic busy;
    assign busy = (st_reg != HS_IDLE);
    assign PINS.host_select_n = SW_MODE ? !busy : 1'b0;
    assign PINS.write_n       = SW_MODE ? !(busy && wr_reg) : 1'b0;
    assign PINS.read_n        = SW_MODE ? !(busy && !wr_reg) : 1'b0;
    assign PINS.reg_sel       = a_reg;
    // Straps on bits 1..5; bit 0 and 6 belong to device outputs
    assign PINS.bus_host_o    = SW_MODE ? d_reg
                                : {2'b00, TEST_STRAPS, 1'b0};
    assign PINS.bus_host_oe   = SW_MODE ? (busy && wr_reg) : 1'b1;
    assign DONE      = done_reg;
    assign RDATA     = rd_reg;
    assign FLAG_SEEN = flg_sync_reg[1];
endmodule

// ===== src/hwc_if.sv
// Pin-level carrier between host/strap logic and the transceiver end
interface hwc_if;
    logic       host_select_n;
    logic       write_n;
    logic       read_n;
    logic [3:0] reg_sel;
    logic [7:0] bus_host_o;
    logic       bus_host_oe;
    logic [7:0] bus_dev_o;
    logic       bus_dev_oe;
    logic       sync_loss_timer_flag;
    logic       rx_baud_clock;
    // Resolved level of the shared test/data pins, pull-down when idle
    wire  [7:0] bus = bus_host_oe ? bus_host_o :
                      bus_dev_oe  ? bus_dev_o  : 8'h00;
    modport dev  (input host_select_n, write_n, read_n, reg_sel,
                  bus_host_o, bus_host_oe, bus,
                  output bus_dev_o, bus_dev_oe,
                  sync_loss_timer_flag, rx_baud_clock);
    modport host (output host_select_n, write_n, read_n, reg_sel,
                  bus_host_o, bus_host_oe,
                  input bus_dev_o, bus_dev_oe, bus,
                  sync_loss_timer_flag, rx_baud_clock);
endinterface

// ===== src/hwc_pkg.sv
// Shared constants and types for the hardware-control test and host pins
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package hwc_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned BAUD_HZ       = 584_000;
    // Half period of the baud clock, rounded down (shortest time)
    localparam int unsigned BAUD_HALF_CYC = CLK_HZ / (2 * BAUD_HZ);
    localparam int unsigned SYNC_LOSS_S   = 2;
    // Least time: more than 2 s, counted in whole cycles
    localparam int unsigned SYNC_LOSS_CYC = SYNC_LOSS_S * CLK_HZ;
    localparam int unsigned ISOLATED_PULSE_TEST_MS      = 6;
    localparam int unsigned ISOLATED_PULSE_TEST_CYC     = ISOLATED_PULSE_TEST_MS * (CLK_HZ / 1000);
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned ADDR_W        = 4;
    localparam logic [10:0] SYNC_WORD     = 11'h5E3;
    localparam logic [22:0] SCR_SEED      = 23'h7FFFFF;
    typedef enum logic [1:0] {
        HWC_INACTIVE, HWC_ACTIVATING, HWC_ACTIVE
    } hwc_state_t;
endpackage

// ===== tb/hwc_asserts.sv
// Assertions on the pin carrier between the host and device ends
module hwc_asserts
    import hwc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic host_select_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic bus_host_oe,
    input wire logic bus_dev_oe,
    input wire logic rx_baud_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    //--------------------
    // Helpers
    //--------------------
    logic       rd_sel;
    logic       last_reg;
    logic [7:0] half_reg;
    logic [7:0] half_next;
    // Software read cycle; write idle keeps hardware mode out
    assign rd_sel = !host_select_n && !read_n && write_n;
    // Cycles since the last baud clock edge
    always_comb begin
        half_next = (rx_baud_clock != last_reg) ? 8'h00 : half_reg + 8'h01;
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            half_reg <= 8'h00;
            last_reg <= 1'b0;
        end else begin
            half_reg <= half_next;
            last_reg <= rx_baud_clock;
        end
    end
    //--------------------
    // Properties
    //--------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    sequence s_wr_go; $fell(write_n) && read_n && !host_select_n; endsequence
    sequence s_rd_go; $fell(read_n) && write_n && !host_select_n; endsequence
    a_wr_strobe_len: assert property (s_wr_go |=>
        !write_n ##1 !write_n ##1 write_n)
        else $error("write strobe length wrong");
    a_rd_strobe_len: assert property (s_rd_go |=>
        !read_n ##1 !read_n ##1 read_n)
        else $error("read strobe length wrong");
    a_sel_with_strobe: assert property ($fell(host_select_n) |->
        !write_n || !read_n) else $error("select without strobe");
    a_host_drive_ok: assert property (bus_host_oe |->
        !host_select_n && !write_n) else $error("host drives outside write");
    a_no_bus_fight: assert property (!(bus_host_oe && bus_dev_oe))
        else $error("both ends drive the bus");
    a_hw_dev_quiet: assert property ((!host_select_n && !write_n &&
        !read_n)[*4] |-> !bus_dev_oe) else $error("device drives in hw mode");
    a_dev_drive_cause: assert property ($rose(bus_dev_oe) |->
        $past(rd_sel, 2) || $past(rd_sel, 3)) else $error("drive without read");
    a_dev_release: assert property ($rose(read_n) && write_n |->
        ##[0:4] !bus_dev_oe) else $error("device holds bus after read");
    a_baud_half: assert property (half_reg <= BAUD_HALF_CYC)
        else $error("baud half period too long");
endmodule

// ===== tb/hwc_tb_top.sv
// Bench joining the host end and device end over the pin carrier
module hwc_tb_top import hwc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned LOSS = 100;
    localparam int unsigned TXT  = 50;
    `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
        bad_count++; $display("wrong value %s exp %0h got %0h", n, e, g); \
        end end
    logic        mclk, rst_n, sw_mode, req, req_write, done, flag_seen;
    logic        sync_lost, line_side, tx_data, tx_fp, rx_din, rx_fin;
    logic        rx_dout, rx_fout, tx_valid, fe_loop, act_ok, reg_we, rx_bit;
    logic        rx_sym, interface_clock;
    logic [1:0]  link_state, tx_quat, r;
    logic [3:0]  req_addr, reg_addr, a;
    logic [4:0]  straps;
    logic [7:0]  req_wdata, rdata, reg_wdata, reg_rdata, d;
    logic [7:0]  mem [16];
    logic [11:0] wr_q [$];
    logic [8:0]  done_q [$];
    logic [11:0] ew;
    logic [8:0]  ed;
    int          bad_count, compares, seed, n;
    hwc_if       pins ();
    wire  [2:0]  ctl = {pins.host_select_n, pins.write_n, pins.read_n};

    hwc_host hwc_host_inst (
        .MCLK(mclk), .RST_N(rst_n), .PINS(pins), .SW_MODE(sw_mode),
        .TEST_STRAPS(straps), .REQ(req), .REQ_WRITE(req_write),
        .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .DONE(done),
        .RDATA(rdata), .FLAG_SEEN(flag_seen));
    hwc_dev #(.SYNC_LOSS_CYCLES(LOSS), .ISOLATED_PULSE_TEST_CYCLES(TXT)) hwc_dev_inst (
        .MCLK(mclk), .RST_N(rst_n), .PINS(pins), .LINE_SIDE(line_side),
        .SYNC_WORD_LOST(sync_lost), .LINK_STATE(link_state),
        .TX_DATA(tx_data), .TX_FRAME_PULSE(tx_fp), .RX_DATA_IN(rx_din),
        .RX_FRAME_IN(rx_fin), .LINE_RX_BIT(rx_bit), .RX_SYMBOL_STROBE(rx_sym),
        .LINE_TX_VALID(tx_valid), .LINE_TX_QUAT(tx_quat),
        .RX_DATA_OUT(rx_dout), .RX_FRAME_OUT(rx_fout),
        .INTERFACE_CLOCK(interface_clock), .FE_LOOP(fe_loop), .ACT_ALLOWED(act_ok),
        .REG_WE(reg_we), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata));
    hwc_asserts hwc_asserts_inst (
        .MCLK(mclk), .RST_N(rst_n), .host_select_n(pins.host_select_n),
        .write_n(pins.write_n), .read_n(pins.read_n),
        .bus_host_oe(pins.bus_host_oe), .bus_dev_oe(pins.bus_dev_oe),
        .rx_baud_clock(pins.rx_baud_clock));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Register file behind the device; reads see the last write
    always @(posedge mclk) begin
        if (reg_we === 1'b1) mem[reg_addr] <= reg_wdata;
        rx_bit <= 1'($urandom);
    end
    assign reg_rdata = mem[reg_addr];
    // Monitor: each result takes the oldest expectation
    always @(posedge mclk) begin
        if (reg_we === 1'b1) begin
            ew = wr_q.size() ? wr_q.pop_front() : 'x;
            `CHK("reg write", ew, {reg_addr, reg_wdata})
        end
        if (done === 1'b1) begin
            ed = done_q.size() ? done_q.pop_front() : 'x;
            if (ed[8] !== 1'b0) `CHK("read data", ed[7:0], rdata)
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask
    // Edges until the next transmit pulse, bounded
    task automatic wait_tx(output int k);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (tx_valid !== 1'b1 && k < 200);
    endtask
    task automatic wait_baud(input logic v, inout int k);
        while (pins.rx_baud_clock !== v && k < 300) begin
            @(posedge mclk);
            k++;
        end
    endtask
    // One host access; the note goes in before the request
    task automatic access(input logic w, input logic [3:0] ad,
                          input logic [7:0] dt);
        int k;
        if (w) wr_q.push_back({ad, dt});
        done_q.push_back({!w, dt});
        @(posedge mclk);
        {req, req_write, req_addr, req_wdata} <= {1'b1, w, ad, dt};
        @(posedge mclk);
        req <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 30) begin
            @(posedge mclk);
            k++;
        end
        `CHK("access done", 1'b1, done)
        tick(10);
    endtask
    task automatic finish_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog, well beyond the expected run length
    initial begin
        tick(40000);
        bad_count++;
        finish_test();
    end

    initial begin
        seed = $urandom(20024);
        {rst_n, sw_mode, req, req_write, req_addr, req_wdata} = '0;
        {sync_lost, line_side, link_state, tx_data, tx_fp} = '0;
        {rx_din, rx_fin, rx_sym, straps} = '0;
        tick(12);
        rst_n <= 1'b1;
        tick(2);
        // Hardware mode: straps appear on the shared pins
        for (int i = 0; i < 8; i++) begin
            straps <= 5'($urandom);
            tick(3);
            `CHK("strap pins", straps, pins.bus[5:1])
            `CHK("controls", 3'b000, ctl)
        end
        // Sync loss with a one-cycle break restarts the timer
        sync_lost <= 1'b1;
        tick(60);
        sync_lost <= 1'b0;
        tick(1);
        sync_lost <= 1'b1;
        tick(95);
        `CHK("flag early", 1'b0, pins.sync_loss_timer_flag)
        tick(15);
        `CHK("flag late", 1'b1, pins.sync_loss_timer_flag)
        `CHK("flag seen", 1'b1, flag_seen)
        sync_lost <= 1'b0;
        // Baud clock period in cycles
        n = 0;
        wait_baud(1'b0, n);
        wait_baud(1'b1, n);
        n = 0;
        wait_baud(1'b0, n);
        wait_baud(1'b1, n);
        `CHK("baud period", 2 * BAUD_HALF_CYC, n)
        // Network side: a symbol strobe in the low phase restarts the half
        wait_baud(1'b0, n);
        rx_sym <= 1'b1;
        tick(1);
        rx_sym <= 1'b0;
        tick(1);
        `CHK("rephase level", 1'b1, pins.rx_baud_clock)
        n = 0;
        wait_baud(1'b0, n);
        `CHK("rephase half", BAUD_HALF_CYC, n)
        // Isolated pulses: gap and every quat code
        straps <= 5'h01;
        wait_tx(n);
        for (int q = 0; q < 4; q++) begin
            {tx_data, tx_fp} <= 2'(q);
            wait_tx(n);
            `CHK("quat", 2'(q), tx_quat)
            `CHK("pulse gap", TXT, n)
        end
        // Insertion-loss test opens with the sync word, one bit a symbol
        straps <= 5'h02;
        for (int i = 0; i < 11; i++) begin
            wait_tx(n);
            r = {SYNC_WORD[i], 1'b0};
            `CHK("insertion_loss_test pulses", 1'b1, tx_valid)
            `CHK("sync word", r, tx_quat)
        end
        `CHK("act allowed", 1'b1, act_ok)
        // Back-end loopback on, then off, in the active state
        link_state <= 2'd2;
        for (int lb = 1; lb >= 0; lb--) begin
            straps <= lb ? 5'h10 : 5'h00;
            tick(4);
            for (int i = 0; i < 8; i++) begin
                r = 2'($urandom);
                {tx_data, tx_fp} <= r;
                {rx_din, rx_fin} <= ~r;
                tick(2);
                `CHK("loop data", lb ? r : ~r, {rx_dout, rx_fout})
            end
        end
        // Front-end loopback honoured on the line side only
        link_state <= 2'd0;
        line_side <= 1'b1;
        straps <= 5'h08;
        {rx_din, rx_fin} <= 2'b11;
        tick(5);
        `CHK("fe loop", 1'b1, fe_loop)
        `CHK("fe ignores far", 1'b0, rx_dout)
        line_side <= 1'b0;
        tick(4);
        `CHK("fe loop off", 1'b0, fe_loop)
        // Repeater on the line side: interface clock follows frame pulse
        line_side <= 1'b1;
        straps <= 5'h04;
        tick(3);
        for (int i = 0; i < 4; i++) begin
            tx_fp <= i[0];
            tick(2);
            `CHK("interface_clock follows", i[0], interface_clock)
        end
        // Software mode: write then read back six random addresses
        straps <= 5'h00;
        sw_mode <= 1'b1;
        tick(4);
        for (int i = 0; i < 6; i++) begin
            a = 4'($urandom);
            d = 8'($urandom);
            access(1'b1, a, d);
            access(1'b0, a, d);
        end
        `CHK("writes left", 0, wr_q.size())
        finish_test();
    end
endmodule
